/* File: verilog/sdh_pkg.sv */
// Shared constants for the storage card DMA and I/O read handshake.
// Assumes both ends run on a 50 MHz core clock.
`default_nettype none

package sdh_pkg;

	////////////////////////////////////////////////////////////////////
	// Operating modes, as driven on the mode lines
	localparam logic [1:0] MODE_MEM = 2'h0;
	localparam logic [1:0] MODE_IO = 2'h1;
	localparam logic [1:0] MODE_IDE = 2'h2;

	////////////////////////////////////////////////////////////////////
	// Device side: bit positions in the synchronised pin vector
	localparam int PV_IORD = 0;
	localparam int PV_IOWR = 1;
	localparam int PV_DMACK = 2;
	localparam int PV_REG = 3;
	localparam int PV_CE = 4;
	localparam int PV_MODE = 5;
	localparam int PV_DATA = 7;
	localparam int PV_W = 23;

	// Host side: bit positions in its synchronised pin vector
	localparam int HV_DMARQ = 0;
	localparam int HV_INPACK = 1;
	localparam int HV_DSTROBE = 2;
	localparam int HV_RDY = 3;
	localparam int HV_DATA = 4;
	localparam int HV_W = 20;

	////////////////////////////////////////////////////////////////////
	// Timing, in ns, and derived cycle counts (least times round up)
	localparam int CLK_NS = 20;
	localparam int PIO_NS = 160;
	localparam int MW_NS = 160;
	localparam int HS_HALF_NS = 80;
	localparam int STOP_NS = 80;
	localparam int GAP_NS = 80;
	localparam logic [3:0] PIO_CYC = 4'((PIO_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] MW_CYC = 4'((MW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] HS_CYC = 4'((HS_HALF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] STOP_CYC = 4'((STOP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] GAP_CYC = 4'((GAP_NS + CLK_NS - 1) / CLK_NS);

	////////////////////////////////////////////////////////////////////
	// State machines
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_REQ = 3'b001,
		D_MW = 3'b010,
		D_UWAIT = 3'b011,
		D_UDMA = 3'b100
	} sdh_dst_e;

	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_PIO = 3'b001,
		H_ACK = 3'b010,
		H_MW = 3'b011,
		H_UDMA = 3'b100,
		H_STOP = 3'b101
	} sdh_hst_e;

endpackage

`default_nettype wire

/* File: verilog/sdh_if.sv */
// Pin bundle between the card and the host controller.
// Two-way lines are resolved here from each end's output enable (low = driving).
`timescale 1ns/1ps
`default_nettype none

interface sdh_if;
	logic [1:0] mode;
	logic ce_n;
	logic reg_n;
	logic iord_n;
	logic iowr_n;
	logic dmack_n;
	logic dmarq;
	logic dmarq_oe_n;
	logic inpack_n;
	logic dstrobe;
	logic rdy_n;
	logic [15:0] dev_d;
	logic dev_d_oe_n;
	logic [15:0] host_d;
	logic host_d_oe_n;
	logic [15:0] d;
	logic dmarq_w;

	// Released request line reads low, as a pull-down would make it
	assign dmarq_w = !dmarq_oe_n && dmarq;
	assign d = !dev_d_oe_n ? dev_d : (!host_d_oe_n ? host_d : 16'h0000);

	modport dev (
		input mode, ce_n, reg_n, iord_n, iowr_n, dmack_n, d,
		output dmarq, dmarq_oe_n, inpack_n, dstrobe, rdy_n, dev_d, dev_d_oe_n
	);

	modport host (
		input dmarq_w, inpack_n, dstrobe, rdy_n, d,
		output mode, ce_n, reg_n, iord_n, iowr_n, dmack_n, host_d, host_d_oe_n
	);
endinterface

`default_nettype wire

/* File: verilog/sdh_dev.sv */
// Card end: I/O read acknowledge, read data gating and the DMA handshake.
// Assumes every pin from the host is asynchronous to i_core_clk.
//
// How it works
// - memory mode: no acknowledge, read strobe ignored
// - I/O mode: acknowledge only on own reads
// - IDE mode: request when ready to move data
// - strobe choice sets multiword transfer direction; here i_dir_in sets it and the other strobe is ignored
// - hold request until acknowledge, reassert for more
// - release request line when not selected
// - host negates selects; transfers are 16 bits
// - I/O mode: drive read data during strobe
// - IDE without Ultra DMA reads like I/O
// - host asserts ready during data-in burst
// - stop sending while host ready negated
// - capture a word on each strobe edge
// - missing strobe edges mean pause only
// - host acknowledges request to start transfer
// - ignore acknowledge while no DMA is active, except IDE mode reads need it negated
// - end Ultra DMA burst on host stop
`timescale 1ns/1ps
`default_nettype none

module sdh_dev (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	sdh_if.dev bus,
	input wire logic i_sel,
	input wire logic i_dma_en,
	input wire logic i_udma,
	input wire logic i_dir_in,
	input wire logic [15:0] i_pio_data,
	input wire logic i_wr_valid,
	input wire logic [15:0] i_wr_data,
	output logic o_wr_ready,
	output logic o_rd_valid,
	output logic [15:0] o_rd_data,
	input wire logic i_rd_ready,
	output logic o_pio_rd
);

	////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [sdh_pkg::PV_W-1:0] sy1;
		logic [sdh_pkg::PV_W-1:0] sy2;
		logic [sdh_pkg::PV_W-1:0] prv;
		sdh_pkg::sdh_dst_e st;
		logic [3:0] gap;
		logic v0;
		logic v1;
		logic [15:0] m0;
		logic [15:0] m1;
		logic wr_ready;
		logic rd_valid;
		logic dmarq;
		logic dmarq_oe_n;
		logic inpack_n;
		logic d_oe_n;
		logic [15:0] d;
		logic dstrobe;
		logic rdy_n;
		logic pio_rd;
	} sdh_dev_s;

	sdh_dev_s st;
	sdh_dev_s n;

	logic iord_n;
	logic iowr_n;
	logic dmack_n;
	logic reg_n;
	logic ce_n;
	logic [1:0] mode;
	logic [15:0] din;
	logic iord_rise;
	logic iord_edge;
	logic iowr_rise;
	logic ide;
	logic room;
	logic pio;
	logic push;
	logic pop;
	logic [15:0] wd;

	////////////////////////////////////////////////////////////////////
	// Synchronised pins; the second stage is read, with a copy one cycle older for edges

	assign iord_n = st.sy2[sdh_pkg::PV_IORD];
	assign iowr_n = st.sy2[sdh_pkg::PV_IOWR];
	assign dmack_n = st.sy2[sdh_pkg::PV_DMACK];
	assign reg_n = st.sy2[sdh_pkg::PV_REG];
	assign ce_n = st.sy2[sdh_pkg::PV_CE];
	assign mode = st.sy2[sdh_pkg::PV_MODE +: 2];
	assign din = st.sy2[sdh_pkg::PV_DATA +: 16];
	assign iord_edge = st.sy2[sdh_pkg::PV_IORD] ^ st.prv[sdh_pkg::PV_IORD];
	assign iord_rise = iord_edge && iord_n;
	assign iowr_rise = iowr_n && !st.prv[sdh_pkg::PV_IOWR];
	assign ide = (mode == sdh_pkg::MODE_IDE);
	// Data-in needs a held word, data-out a free slot
	assign room = i_dir_in ? st.v0 : !st.v1;

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		n = st;
		push = 1'b0;
		pop = 1'b0;
		wd = i_wr_data;
		n.sy1 = {bus.d, bus.mode, bus.ce_n, bus.reg_n, bus.dmack_n,
			bus.iowr_n, bus.iord_n};
		n.sy2 = st.sy1;
		n.prv = st.sy2;
		if (st.rd_valid && i_rd_ready) begin
			pop = 1'b1;
		end
		if (st.wr_ready && i_wr_valid) begin
			push = 1'b1;
		end

		unique case (st.st)
			sdh_pkg::D_IDLE: begin
				// Acknowledge line not looked at here, floating or not
				if (ide && i_sel && i_dma_en && room) begin
					n.st = sdh_pkg::D_REQ;
				end
			end
			sdh_pkg::D_REQ: begin
				// Request stays up until acknowledged
				// Fresh falling edge only; a tail left low from the last burst is no ack
				if (!dmack_n && st.prv[sdh_pkg::PV_DMACK]) begin
					n.st = i_udma ? sdh_pkg::D_UWAIT : sdh_pkg::D_MW;
					n.gap = 4'h0;
				end
			end
			sdh_pkg::D_MW: begin
				// Straight back to request if work is left, so the line never dips
				if (dmack_n) begin
					n.st = (ide && i_sel && i_dma_en && room) ? sdh_pkg::D_REQ
						: sdh_pkg::D_IDLE;
				end else if (i_dir_in) begin
					// Read strobe moves words to the host
					if (iord_rise && st.v0) begin
						pop = 1'b1;
					end
				end else if (iowr_rise && !st.v1) begin
					// Write strobe moves full words to the card
					push = 1'b1;
					wd = din;
				end
			end
			sdh_pkg::D_UWAIT: begin
				// Stop still asserted from before the burst
				if (dmack_n) begin
					n.st = sdh_pkg::D_IDLE;
				end else if (!iowr_n) begin
					n.st = sdh_pkg::D_UDMA;
				end
			end
			sdh_pkg::D_UDMA: begin
				if (iowr_n || dmack_n) begin
					n.st = sdh_pkg::D_IDLE;
				end else if (i_dir_in) begin
					if (st.gap != 4'h0) begin
						n.gap = st.gap - 4'h1;
					end else if (!iord_n && st.v0) begin
						// Host ready gates each word
						n.d = st.m0;
						n.dstrobe = !st.dstrobe;
						pop = 1'b1;
						n.gap = sdh_pkg::GAP_CYC - 4'h1;
					end
				end else if (iord_edge && !st.v1) begin
					// Both strobe edges; no timeout while edges stop
					push = 1'b1;
					wd = din;
				end
			end
			default: begin
				n.st = sdh_pkg::D_IDLE;
			end
		endcase

		////////////////////////////////////////////////////////////////
		// Two-entry buffer, head in slot 0

		if (pop) begin
			n.m0 = st.m1;
			n.v0 = st.v1;
			n.v1 = 1'b0;
		end
		if (push) begin
			if (!n.v0) begin
				n.m0 = wd;
				n.v0 = 1'b1;
			end else begin
				n.m1 = wd;
				n.v1 = 1'b1;
			end
		end
		n.wr_ready = i_dir_in && !n.v1;
		n.rd_valid = !i_dir_in && n.v0;
		// Pause data-out once a word waits; leaves one slot for a word in flight
		n.rdy_n = !(n.st == sdh_pkg::D_UDMA && !i_dir_in && !n.v0);

		////////////////////////////////////////////////////////////////
		// Request line

		n.dmarq = ide && (n.st == sdh_pkg::D_REQ || n.st == sdh_pkg::D_UWAIT
			|| n.st == sdh_pkg::D_UDMA || (n.st == sdh_pkg::D_MW && room));
		n.dmarq_oe_n = !(ide && i_sel);

		////////////////////////////////////////////////////////////////
		// I/O read acknowledge and read data gating

		n.inpack_n = !(mode == sdh_pkg::MODE_IO && !ce_n && !reg_n
			&& !iord_n);
		pio = !ce_n && !iord_n && (mode == sdh_pkg::MODE_IO
			|| (ide && dmack_n && st.st != sdh_pkg::D_UDMA
			&& st.st != sdh_pkg::D_UWAIT));
		n.pio_rd = pio;
		if (pio) begin
			n.d = i_pio_data;
		end else if (st.st == sdh_pkg::D_MW && i_dir_in) begin
			n.d = st.m0;
		end
		n.d_oe_n = !(pio || (st.st == sdh_pkg::D_MW && i_dir_in && !iord_n
			&& !dmack_n) || (n.st == sdh_pkg::D_UDMA && i_dir_in));
	end

	////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= '0;
			st.sy1[sdh_pkg::PV_CE:sdh_pkg::PV_IORD] <= 5'h1f;
			st.sy2[sdh_pkg::PV_CE:sdh_pkg::PV_IORD] <= 5'h1f;
			st.prv[sdh_pkg::PV_CE:sdh_pkg::PV_IORD] <= 5'h1f;
			st.dmarq_oe_n <= 1'b1;
			st.inpack_n <= 1'b1;
			st.d_oe_n <= 1'b1;
			st.rdy_n <= 1'b1;
		end else begin
			st <= n;
		end
	end

	assign bus.dmarq = st.dmarq;
	assign bus.dmarq_oe_n = st.dmarq_oe_n;
	assign bus.inpack_n = st.inpack_n;
	assign bus.dstrobe = st.dstrobe;
	assign bus.rdy_n = st.rdy_n;
	assign bus.dev_d = st.d;
	assign bus.dev_d_oe_n = st.d_oe_n;
	assign o_wr_ready = st.wr_ready;
	assign o_rd_valid = st.rd_valid;
	assign o_rd_data = st.m0;
	assign o_pio_rd = st.pio_rd;

endmodule

`default_nettype wire

/* File: verilog/sdh_host.sv */
// Host end: I/O read cycles, DMA acknowledge and both DMA burst kinds.
// Assumes the card pins are asynchronous to i_core_clk.
`timescale 1ns/1ps
`default_nettype none

module sdh_host (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	sdh_if.host bus,
	input wire logic [1:0] i_mode,
	input wire logic i_ce_n,
	input wire logic i_io_rd,
	output logic o_io_done,
	output logic [15:0] o_io_data,
	input wire logic i_dma_go,
	input wire logic i_udma,
	input wire logic i_dir_in,
	input wire logic i_pause,
	input wire logic i_stop,
	input wire logic i_tx_valid,
	input wire logic [15:0] i_tx_data,
	output logic o_tx_ready,
	output logic o_rx_valid,
	output logic [15:0] o_rx_data
);

	typedef struct packed {
		logic [sdh_pkg::HV_W-1:0] sy1;
		logic [sdh_pkg::HV_W-1:0] sy2;
		logic [sdh_pkg::HV_W-1:0] prv;
		sdh_pkg::sdh_hst_e st;
		logic [3:0] cnt;
		logic ph;
		logic [1:0] mode;
		logic ce_n;
		logic reg_n;
		logic iord_n;
		logic iowr_n;
		logic dmack_n;
		logic [15:0] d;
		logic d_oe_n;
		logic hv;
		logic [15:0] hd;
		logic tx_ready;
		logic rx_valid;
		logic [15:0] rx_data;
		logic io_done;
		logic [15:0] io_data;
	} sdh_host_s;

	sdh_host_s st;
	sdh_host_s n;

	logic dmarq;
	logic rdy_n;
	logic ds_edge;
	logic [15:0] din;

	assign dmarq = st.sy2[sdh_pkg::HV_DMARQ];
	assign rdy_n = st.sy2[sdh_pkg::HV_RDY];
	assign ds_edge = st.sy2[sdh_pkg::HV_DSTROBE] ^ st.prv[sdh_pkg::HV_DSTROBE];
	assign din = st.sy2[sdh_pkg::HV_DATA +: 16];

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		n = st;
		n.sy1 = {bus.d, bus.rdy_n, bus.dstrobe, bus.inpack_n, bus.dmarq_w};
		n.sy2 = st.sy1;
		n.prv = st.sy2;
		n.mode = i_mode;
		n.rx_valid = 1'b0;
		n.io_done = 1'b0;
		if (st.tx_ready && i_tx_valid) begin
			n.hv = 1'b1;
			n.hd = i_tx_data;
		end

		unique case (st.st)
			sdh_pkg::H_IDLE: begin
				if (i_io_rd) begin
					n.iord_n = 1'b0;
					n.reg_n = 1'b0;
					n.cnt = sdh_pkg::PIO_CYC - 4'h1;
					n.st = sdh_pkg::H_PIO;
				end else if (dmarq && i_dma_go && i_mode == sdh_pkg::MODE_IDE) begin
					n.dmack_n = 1'b0;
					n.cnt = 4'h1;
					n.st = sdh_pkg::H_ACK;
				end
			end
			sdh_pkg::H_PIO: begin
				if (st.cnt != 4'h0) begin
					n.cnt = st.cnt - 4'h1;
				end else begin
					n.io_done = 1'b1;
					n.io_data = din;
					n.iord_n = 1'b1;
					n.reg_n = 1'b1;
					n.st = sdh_pkg::H_IDLE;
				end
			end
			sdh_pkg::H_ACK: begin
				if (st.cnt != 4'h0) begin
					n.cnt = st.cnt - 4'h1;
				end else if (i_udma) begin
					n.iowr_n = 1'b0;
					n.iord_n = i_dir_in ? i_pause : 1'b1;
					n.st = sdh_pkg::H_UDMA;
				end else begin
					n.ph = 1'b0;
					n.st = sdh_pkg::H_MW;
				end
			end
			sdh_pkg::H_MW: begin
				if (st.cnt != 4'h0) begin
					n.cnt = st.cnt - 4'h1;
				end else if (st.ph) begin
					n.ph = 1'b0;
					n.iord_n = 1'b1;
					n.iowr_n = 1'b1;
					n.cnt = sdh_pkg::MW_CYC - 4'h1;
					if (i_dir_in) begin
						n.rx_valid = 1'b1;
						n.rx_data = din;
					end
				end else if (!dmarq) begin
					n.dmack_n = 1'b1;
					n.d_oe_n = 1'b1;
					n.st = sdh_pkg::H_IDLE;
				end else if (i_dir_in || st.hv) begin
					// Read strobe for data-in, write strobe for data-out
					n.ph = 1'b1;
					n.cnt = sdh_pkg::MW_CYC - 4'h1;
					n.iord_n = !i_dir_in;
					n.iowr_n = i_dir_in;
					if (!i_dir_in) begin
						n.d = st.hd;
						n.d_oe_n = 1'b0;
						n.hv = 1'b0;
					end
				end
			end
			sdh_pkg::H_UDMA: begin
				if (i_stop || !dmarq) begin
					n.iowr_n = 1'b1;
					n.cnt = sdh_pkg::STOP_CYC - 4'h1;
					n.st = sdh_pkg::H_STOP;
				end else if (i_dir_in) begin
					n.iord_n = i_pause;
					if (ds_edge) begin
						n.rx_valid = 1'b1;
						n.rx_data = din;
					end
				end else if (st.cnt != 4'h0) begin
					n.cnt = st.cnt - 4'h1;
				end else if (st.hv && !i_pause && !rdy_n) begin
					// Strobe from a divider of the core clock
					n.d = st.hd;
					n.d_oe_n = 1'b0;
					n.iord_n = !st.iord_n;
					n.hv = 1'b0;
					n.cnt = sdh_pkg::HS_CYC - 4'h1;
				end
			end
			sdh_pkg::H_STOP: begin
				if (st.cnt != 4'h0) begin
					n.cnt = st.cnt - 4'h1;
				end else begin
					n.dmack_n = 1'b1;
					n.iord_n = 1'b1;
					n.d_oe_n = 1'b1;
					n.st = sdh_pkg::H_IDLE;
				end
			end
			default: begin
				n.st = sdh_pkg::H_IDLE;
			end
		endcase

		n.tx_ready = !n.hv;
		// Selects held negated through any DMA operation
		n.ce_n = i_ce_n || !n.dmack_n;
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st <= '0;
			st.ce_n <= 1'b1;
			st.reg_n <= 1'b1;
			st.iord_n <= 1'b1;
			st.iowr_n <= 1'b1;
			st.dmack_n <= 1'b1;
			st.d_oe_n <= 1'b1;
		end else begin
			st <= n;
		end
	end

	assign bus.mode = st.mode;
	assign bus.ce_n = st.ce_n;
	assign bus.reg_n = st.reg_n;
	assign bus.iord_n = st.iord_n;
	assign bus.iowr_n = st.iowr_n;
	assign bus.dmack_n = st.dmack_n;
	assign bus.host_d = st.d;
	assign bus.host_d_oe_n = st.d_oe_n;
	assign o_io_done = st.io_done;
	assign o_io_data = st.io_data;
	assign o_tx_ready = st.tx_ready;
	assign o_rx_valid = st.rx_valid;
	assign o_rx_data = st.rx_data;

endmodule

`default_nettype wire

/* File: test/sdh_chk_sva.sv */
// Pin-level checks on the card/host link, watching the shared interface.
// Assumes the bench wires it beside the interface, by name, with no bind.
`timescale 1ns/1ps
`default_nettype none

module sdh_chk (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [1:0] mode,
	input wire logic ce_n,
	input wire logic reg_n,
	input wire logic iord_n,
	input wire logic iowr_n,
	input wire logic dmack_n,
	input wire logic dmarq_w,
	input wire logic dmarq_oe_n,
	input wire logic inpack_n,
	input wire logic dev_d_oe_n,
	input wire logic dstrobe
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	////////////////////////////////////////////////////////////////
	sequence s_io_read;
		$fell(iord_n) && !ce_n && !reg_n && mode == sdh_pkg::MODE_IO;
	endsequence
	// Five cycles so the card's sync chain has seen the host not ready
	sequence s_paused;
		(!dmack_n && !iowr_n && iord_n) [*5];
	endsequence

	////////////////////////////////////////////////////////////////
	a_mem_no_ack: assert property (mode == sdh_pkg::MODE_MEM |-> inpack_n)
		else $error("acknowledge in memory mode");
	a_mem_no_drive: assert property (mode == sdh_pkg::MODE_MEM |-> dev_d_oe_n)
		else $error("card drives data in memory mode");
	a_ack_cause: assert property ($fell(inpack_n) |-> !iord_n && !ce_n && !reg_n)
		else $error("acknowledge without a read cycle");
	a_ack_follows: assert property (s_io_read |-> ##[1:5] !inpack_n)
		else $error("read cycle not acknowledged");
	a_io_data_ack: assert property (mode == sdh_pkg::MODE_IO |-> dev_d_oe_n == inpack_n)
		else $error("read data not gated with acknowledge");
	a_rq_released: assert property (mode != sdh_pkg::MODE_IDE |-> dmarq_oe_n)
		else $error("request driven outside ide mode");
	a_rq_held: assert property (dmarq_w && dmack_n |=> dmarq_w)
		else $error("request dropped before acknowledge");
	a_dma_no_sel: assert property (!dmack_n |-> ce_n)
		else $error("select asserted during dma");
	a_pause_quiet: assert property (s_paused |-> $stable(dstrobe))
		else $error("card strobe moved while host paused");
endmodule

`default_nettype wire

/* File: test/storage_card_dma_io_handshake_tb.sv */
// Bench joining card and host ends, driving both user sides.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
`default_nettype none

module storage_card_dma_io_handshake_tb;
	logic core_clk, nrst, ce_n, io_rd, dma_go, udma, dir_in, pause, stop;
	logic tx_valid, sel, dma_en, wr_valid, rd_ready;
	logic [1:0] mode;
	logic [15:0] tx_data, pio_data, wr_data, io_data, rx_data, rd_data;
	logic io_done, tx_ready, rx_valid, wr_ready, rd_valid, pio_rd;
	logic [15:0] dq[$];
	logic [15:0] hq[$];
	int n_fail = 0;
	int check_count = 0;

	sdh_if sdh_if_i();
	sdh_dev sdh_dev_i(.i_core_clk(core_clk), .i_nrst(nrst), .bus(sdh_if_i.dev), .i_sel(sel),
		.i_dma_en(dma_en), .i_udma(udma), .i_dir_in(dir_in), .i_pio_data(pio_data),
		.i_wr_valid(wr_valid), .i_wr_data(wr_data), .o_wr_ready(wr_ready),
		.o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_rd_ready(rd_ready), .o_pio_rd(pio_rd));
	sdh_host sdh_host_i(.i_core_clk(core_clk), .i_nrst(nrst), .bus(sdh_if_i.host),
		.i_mode(mode), .i_ce_n(ce_n), .i_io_rd(io_rd), .o_io_done(io_done),
		.o_io_data(io_data), .i_dma_go(dma_go), .i_udma(udma), .i_dir_in(dir_in),
		.i_pause(pause), .i_stop(stop), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
		.o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data));
	sdh_chk sdh_chk_i(.i_core_clk(core_clk), .i_nrst(nrst), .mode(sdh_if_i.mode),
		.ce_n(sdh_if_i.ce_n), .reg_n(sdh_if_i.reg_n), .iord_n(sdh_if_i.iord_n),
		.iowr_n(sdh_if_i.iowr_n), .dmack_n(sdh_if_i.dmack_n), .dmarq_w(sdh_if_i.dmarq_w),
		.dmarq_oe_n(sdh_if_i.dmarq_oe_n), .inpack_n(sdh_if_i.inpack_n),
		.dev_d_oe_n(sdh_if_i.dev_d_oe_n), .dstrobe(sdh_if_i.dstrobe));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
			dq.push_back(rd_data);
		end
		if (rx_valid === 1'b1) begin
			hq.push_back(rx_data);
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("counts: %0d compares, %0d mismatches", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic timed_out();
		n_fail++;
		$display("unexpected at %0t: wait ran out, got %h, expected %h", $time, 1'b0, 1'b1);
		stop_test();
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Puts every input back to idle; reused between tests to clear leftover bursts
	task automatic do_reset();
		nrst <= 1'b0;
		mode <= sdh_pkg::MODE_MEM;
		ce_n <= 1'b1;
		io_rd <= 1'b0;
		dma_go <= 1'b0;
		udma <= 1'b0;
		dir_in <= 1'b0;
		pause <= 1'b0;
		stop <= 1'b0;
		tx_valid <= 1'b0;
		tx_data <= 16'h0000;
		sel <= 1'b1;
		dma_en <= 1'b0;
		pio_data <= 16'h0000;
		wr_valid <= 1'b0;
		wr_data <= 16'h0000;
		rd_ready <= 1'b1;
		cycles(12);
		nrst <= 1'b1;
		cycles(4);
	endtask

	task automatic io_read(input logic [1:0] m, input logic [15:0] d, input logic drive);
		logic seen;
		int k;
		seen = 1'b0;
		mode <= m;
		pio_data <= d;
		ce_n <= 1'b0;
		cycles(8);
		io_rd <= 1'b1;
		cycles(1);
		io_rd <= 1'b0;
		for (k = 0; k < 40 && io_done !== 1'b1; k++) begin
			cycles(1);
			seen = seen | (pio_rd === 1'b1);
		end
		if (k == 40) timed_out();
		check(io_data, drive ? d : 16'h0000);
		check({15'h0000, seen}, {15'h0000, drive});
		$display("test io read mode %0d done", m);
	endtask

	// Moves n words; the receiver stalls a data-out burst, or the host pauses an Ultra DMA data-in burst, at the start
	task automatic dma(input logic u, input logic din, input int n);
		int k;
		do_reset();
		mode <= sdh_pkg::MODE_IDE;
		ce_n <= 1'b0;
		udma <= u;
		dir_in <= din;
		dma_en <= 1'b1;
		dma_go <= 1'b1;
		dq.delete();
		hq.delete();
		fork
			begin
				wr_valid <= din;
				tx_valid <= !din;
				for (int i = 0; i < n; i++) begin
					wr_data <= 16'hc300 + 16'(i);
					tx_data <= 16'hc300 + 16'(i);
					for (k = 0; k < 400; k++) begin
						cycles(1);
						if ((din ? wr_ready : tx_ready) === 1'b1) break;
					end
					if (k == 400) timed_out();
				end
				wr_valid <= 1'b0;
				tx_valid <= 1'b0;
			end
			begin
				// Card receiver stalls a data-out burst first, then in Ultra DMA the host pauses it; an Ultra DMA data-in burst is host-paused first
				pause <= din & u;
				rd_ready <= din;
				cycles(120);
				pause <= u & !din;
				rd_ready <= 1'b1;
				cycles(120);
				pause <= 1'b0;
			end
		join
		for (k = 0; k < 2000 && (din ? hq.size() : dq.size()) < n; k++) cycles(1);
		if (k == 2000) timed_out();
		cycles(40);
		check(16'(din ? hq.size() : dq.size()), 16'(n));
		for (int i = 0; i < n; i++) begin
			check(din ? hq[i] : dq[i], 16'hc300 + 16'(i));
		end
		if (u) begin
			stop <= 1'b1;
			dma_en <= 1'b0;
			cycles(40);
			check({14'h0000, sdh_if_i.dmarq_w, sdh_if_i.dmack_n}, 16'h0001);
		end
		$display("test dma udma %0d in %0d done", u, din);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		io_read(sdh_pkg::MODE_MEM, 16'h5a3c, 1'b0);
		io_read(sdh_pkg::MODE_IO, 16'ha5c3, 1'b1);
		io_read(sdh_pkg::MODE_IDE, 16'h3cc3, 1'b1);
		do_reset();
		mode <= sdh_pkg::MODE_IDE;
		dma_en <= 1'b1;
		sel <= 1'b0;
		cycles(20);
		check({15'h0000, sdh_if_i.dmarq_oe_n}, 16'h0001);
		sel <= 1'b1;
		cycles(20);
		check({14'h0000, sdh_if_i.dmarq_oe_n, sdh_if_i.dmarq_w}, 16'h0001);
		$display("test request select done");
		dma(1'b0, 1'b0, 5);
		dma(1'b0, 1'b1, 5);
		dma(1'b1, 1'b0, 6);
		dma(1'b1, 1'b1, 6);
		stop_test();
	end
endmodule

`default_nettype wire
